// ==== verilog/wcr_defines.svh ====
// Offsets, field positions, reset values and codes of the wetting current configuration registers.
`ifndef WCR_DEFINES_SVH
`define WCR_DEFINES_SVH

// ****************************************
// Register map
// ****************************************
`define WCR_ADDR_W             6
`define WCR_DATA_W             24
`define WCR_OFS_LOW_INPUTS     6'h1d
`define WCR_OFS_HIGH_INPUTS    6'h1e
`define WCR_RST_LOW_INPUTS     24'h000000
`define WCR_RST_HIGH_INPUTS    24'h000000
`define WCR_HIGH_WR_MASK       24'h7fffff

// ****************************************
// Fields
// ****************************************
`define WCR_FIELD_W            3
`define WCR_SINK_DIS_BIT       22
`define WCR_SOURCE_DIS_BIT     21
`define WCR_SEL_INPUTS         10
`define WCR_NUM_INPUTS         24

// ****************************************
// Field codes
// ****************************************
`define WCR_CODE_OFF           3'h0
`define WCR_CODE_1MA           3'h1
`define WCR_CODE_2MA           3'h2
`define WCR_CODE_5MA           3'h3
`define WCR_CODE_10MA          3'h4

`endif

// ==== verilog/wcr_pkg.sv ====
// Types shared by the wetting current configuration registers.
package wcr_pkg;

	// Applied current level, one-hot free compact code.
	typedef enum logic [2:0] {
		WCR_I_OFF  = 3'h0,
		WCR_I_1MA  = 3'h1,
		WCR_I_2MA  = 3'h2,
		WCR_I_5MA  = 3'h3,
		WCR_I_10MA = 3'h4,
		WCR_I_15MA = 3'h5
	} wcr_level_e;

	// Register access request from the serial port.
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [5:0]  addr;
		logic [23:0] wdata;
	} wcr_req_s;

	// Per-input view delivered to the analog current stage.
	typedef struct packed {
		wcr_level_e level;
		logic       autoscale_en;
	} wcr_chan_s;

endpackage

// ==== verilog/wcr_level_decode.sv ====
// Decode of one 3-bit wetting current field into an applied level.
`timescale 1ns/1ps
`include "wcr_defines.svh"
module wcr_level_decode (
	input  wire logic [2:0]          code,     // Field value from a register.
	output wcr_pkg::wcr_level_e      level,    // Decoded current level.
	output logic                     high_set  // Level is 10 mA or 15 mA.
);

	assign level = (code == `WCR_CODE_OFF)  ? wcr_pkg::WCR_I_OFF  :
	               (code == `WCR_CODE_1MA)  ? wcr_pkg::WCR_I_1MA  :
	               (code == `WCR_CODE_2MA)  ? wcr_pkg::WCR_I_2MA  :
	               (code == `WCR_CODE_5MA)  ? wcr_pkg::WCR_I_5MA  :
	               (code == `WCR_CODE_10MA) ? wcr_pkg::WCR_I_10MA : wcr_pkg::WCR_I_15MA;

	assign high_set = (level == wcr_pkg::WCR_I_10MA) || (level == wcr_pkg::WCR_I_15MA);

endmodule

// ==== verilog/wcr_regs.sv ====
// Wetting current configuration registers and per-input current settings.
// How it works
// - Field codes 0..4 select off, 1, 2, 5 and 10 mA.
// - Codes 5, 6 and 7 all select 15 mA.
// - Register at 1Dh, reset zero, holds eight fields for inputs 0 to 11.
// - Register at 1Eh, reset zero, bit 23 reads zero, fields for inputs 12 to 23.
// - A paired field drives both inputs of its pair identically outside continuous mode.
// - Sink inputs at 10/15 mA drop to 2 mA on closure in continuous mode unless disabled.
// - Source inputs at 10/15 mA drop to 2 mA on closure in continuous mode unless disabled.
// - Inputs 0 to 9 pick sink when their select bit is 1, else source.
`timescale 1ns/1ps
`include "wcr_defines.svh"
module wcr_regs #(
	parameter int NUM_INPUTS = `WCR_NUM_INPUTS  // Switch inputs served.
) (
	input  wire logic                 clk,              // 20 MHz device clock.
	input  wire logic                 rst_n,            // Synchronous reset, active low.
	input  wire wcr_pkg::wcr_req_s    req,              // Register access from the serial port.
	output logic [23:0]               rdata,            // Read data, one cycle after rd.
	output logic                      rvalid,           // Read data valid pulse.
	input  wire logic [9:0]           sink_select,      // Per-input sink select for inputs 0 to 9.
	input  wire logic                 continuous_mode,  // Device is in continuous mode.
	input  wire logic [23:0]          switch_closed,    // Per-input closure state.
	output logic [23:0][2:0]          applied_level     // Level applied to each input.
);

	// ****************************************
	// Register storage
	// ****************************************
	logic [23:0] low_inputs_q;
	logic [23:0] high_inputs_q;
	logic [23:0] rdata_q;
	logic        rvalid_q;
	logic [23:0][2:0] level_q;
	logic [23:0][2:0] level_d;

	wire hit_low  = req.addr == `WCR_OFS_LOW_INPUTS;
	wire hit_high = req.addr == `WCR_OFS_HIGH_INPUTS;
	wire wr_low   = req.wr && hit_low;
	wire wr_high  = req.wr && hit_high;

	// Unmapped addresses read zero.
	wire [23:0] rd_mux = hit_low  ? low_inputs_q :
	                     hit_high ? high_inputs_q : 24'h000000;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			low_inputs_q  <= `WCR_RST_LOW_INPUTS;
			high_inputs_q <= `WCR_RST_HIGH_INPUTS;
		end else begin
			if (wr_low) begin
				low_inputs_q <= req.wdata;
			end
			if (wr_high) begin
				high_inputs_q <= req.wdata & `WCR_HIGH_WR_MASK;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_q  <= 24'h000000;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= req.rd;
			if (req.rd) begin
				rdata_q <= rd_mux;
			end
		end
	end

	assign rdata  = rdata_q;
	assign rvalid = rvalid_q;

	// ****************************************
	// Field to input mapping
	// ****************************************
	// Field index per input: low register bits 2:0 is field 0, high register
	// bits 2:0 is field 8, so input pairs share one index.
	function automatic int field_of(input int n);
		case (n)
			0, 1:   field_of = 0;
			2, 3:   field_of = 1;
			4:      field_of = 2;
			5:      field_of = 3;
			6, 7:   field_of = 4;
			8, 9:   field_of = 5;
			10:     field_of = 6;
			11:     field_of = 7;
			12, 13: field_of = 8;
			14, 15: field_of = 9;
			16, 17: field_of = 10;
			18, 19: field_of = 11;
			20, 21: field_of = 12;
			22:     field_of = 13;
			default: field_of = 14;
		endcase
	endfunction

	wire [47:0] all_fields = {high_inputs_q, low_inputs_q};
	wire sink_dis   = high_inputs_q[`WCR_SINK_DIS_BIT];
	wire source_dis = high_inputs_q[`WCR_SOURCE_DIS_BIT];

	genvar g;
	generate
		for (g = 0; g < NUM_INPUTS; g++) begin : g_in
			wcr_pkg::wcr_level_e lvl;
			logic                high;
			logic                is_sink;
			logic                dis;
			wcr_level_decode u_dec (
				.code     (all_fields[field_of(g)*3 +: 3]),
				.level    (lvl),
				.high_set (high)
			);
			if (g < `WCR_SEL_INPUTS) begin : g_sel
				assign is_sink = sink_select[g];
			end else begin : g_fixed
				assign is_sink = 1'b0;
			end
			assign dis = is_sink ? sink_dis : source_dis;
			assign level_d[g] = (high && !dis && continuous_mode && switch_closed[g]) ?
			                    3'(wcr_pkg::WCR_I_2MA) : 3'(lvl);
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			level_q <= '0;
		end else begin
			level_q <= level_d;
		end
	end

	assign applied_level = level_q;

endmodule

// ==== test/wcr_regs_properties.sv ====
// Port checks for the wetting current registers.
`timescale 1ns/1ps
module wcr_regs_properties (
	input wire logic               clk,             // Clock.
	input wire logic               rst_n,           // Reset.
	input wire wcr_pkg::wcr_req_s  req,             // Access.
	input wire logic [23:0]        rdata,           // Read data.
	input wire logic               rvalid,          // Read valid.
	input wire logic [9:0]         sink_select,     // Sink select.
	input wire logic               continuous_mode, // Mode.
	input wire logic [23:0]        switch_closed,   // Closure.
	input wire logic [23:0][2:0]   applied_level    // Levels.
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [23:0] low_q;
	logic        sink_q;
	logic        src_q;
	logic [2:0]  f12_q;
	// Shadows of the written words, so levels can be judged without the bodies.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{low_q, sink_q, src_q, f12_q} <= '0;
		end else if (req.wr && req.addr == 6'h1d) begin
			low_q <= req.wdata;
		end else if (req.wr && req.addr == 6'h1e) begin
			{sink_q, src_q} <= req.wdata[22:21];
			f12_q <= req.wdata[2:0];
		end
	end
	function automatic logic [2:0] lv(input logic [2:0] c);
		return c > 3'h4 ? 3'h5 : c;
	endfunction
	sequence s_wr_low; req.wr && req.addr == 6'h1d ##1 !req.wr && !continuous_mode; endsequence
	sequence s_wr_rd; req.wr && req.addr == 6'h1d ##1 req.rd && !req.wr && req.addr == 6'h1d; endsequence
	rd_answer_a: assert property (req.rd |=> rvalid) else $error("no rvalid");
	rvalid_cause_a: assert property (rvalid |-> $past(req.rd)) else $error("stray rvalid");
	unmapped_zero_a: assert property (req.rd && !(req.addr inside {6'h1d, 6'h1e}) |=> rdata == 24'h0)
		else $error("unmapped read not zero");
	reserved_zero_a: assert property (req.rd && req.addr == 6'h1e |=> !rdata[23]) else $error("bit 23 set");
	readback_a: assert property (s_wr_rd |=> rdata == low_q) else $error("readback wrong");
	rdata_hold_a: assert property (!req.rd |=> $stable(rdata)) else $error("rdata moved");
	level_decode_a: assert property (s_wr_low |=> applied_level[4] == lv(low_q[8:6])) else $error("bad level");
	pair_same_a: assert property (!$past(continuous_mode) |-> applied_level[0] == applied_level[1] &&
		applied_level[12] == applied_level[13]) else $error("pair differs");
	source_scale_a: assert property ($past(continuous_mode && switch_closed[12] && !src_q && rst_n)
		|-> applied_level[12] == (lv($past(f12_q)) > 3'h3 ? 3'h2 : lv($past(f12_q))))
		else $error("source not scaled");
	sink_scale_a: assert property ($past(continuous_mode && switch_closed[0] && sink_select[0] && !sink_q && rst_n)
		|-> applied_level[0] == (lv($past(low_q[2:0])) > 3'h3 ? 3'h2 : lv($past(low_q[2:0]))))
		else $error("sink not scaled");
	reset_clear_a: assert property (disable iff (1'b0) !rst_n |=> applied_level == '0 && !rvalid && rdata == 24'h0)
		else $error("reset values wrong");
endmodule
bind wcr_regs wcr_regs_properties u_props (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .rvalid(rvalid),
	.sink_select(sink_select), .continuous_mode(continuous_mode), .switch_closed(switch_closed),
	.applied_level(applied_level));

// ==== test/tb.sv ====
// Self-checking bench for the wetting current registers.
`timescale 1ns/1ps
module tb;
	logic clk = 0, rst_n = 0, cm = 0, rvalid;
	wcr_pkg::wcr_req_s req = '0;
	logic [23:0] rdata, lo = 0, hi = 0, cl = 0;
	logic [9:0] sel = 0;
	logic [23:0][2:0] lvl;
	int num_errors = 0, n_compared = 0, cyc = 0;
	int fi [24] = '{0, 0, 1, 1, 2, 3, 4, 4, 5, 5, 6, 7, 0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 5, 6};
	wcr_regs u_dut (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .rvalid(rvalid), .sink_select(sel),
		.continuous_mode(cm), .switch_closed(cl), .applied_level(lvl));
	always #25 clk = ~clk;
	task stop_test;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [24:0] g, input logic [24:0] e);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task acc(input logic w, input logic [5:0] a, input logic [23:0] d);
		@(posedge clk) req <= '{w, !w, a, d};
		@(posedge clk) req <= '0;
		if (w && a == 6'h1d) lo = d;
		if (w && a == 6'h1e) hi = d & 24'h7fffff;
	endtask
	task rd(input logic [5:0] a, input logic [23:0] e);
		acc(0, a, 24'h0);
		#1 chk({rvalid, rdata}, {1'b1, e});
	endtask
	// Expected level per input, with scaling judged from the shadow words.
	task lv_all;
		logic [2:0] c;
		repeat (3) @(posedge clk);
		#1;
		for (int n = 0; n < 24; n++) begin
			c = n < 12 ? lo[3*fi[n]+:3] : hi[3*fi[n]+:3];
			if (c > 3'h4) c = 3'h5;
			if (cm && cl[n] && c > 3'h3 && !((n < 10 && sel[n]) ? hi[22] : hi[21])) c = 3'h2;
			chk({22'h0, lvl[n]}, {22'h0, c});
		end
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			$display("[ERR] %0t timeout", $time);
			stop_test;
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1;
		rd(6'h1d, 24'h0);
		rd(6'h1e, 24'h0);
		for (int c = 0; c < 8; c++) begin
			acc(1, 6'h1d, {8{c[2:0]}});
			acc(1, 6'h1e, {8{c[2:0]}});
			lv_all;
			rd(6'h1d, lo);
			rd(6'h1e, hi);
		end
		acc(1, 6'h1f, 24'hffffff);
		rd(6'h1d, lo);
		rd(6'h1f, 24'h0);
		@(posedge clk) req <= '{1'b1, 1'b0, 6'h1d, 24'h123456};
		@(posedge clk) req <= '{1'b0, 1'b1, 6'h1d, 24'h0};
		@(posedge clk) req <= '0;
		#1 chk({rvalid, rdata}, 25'h1123456);
		rd(6'h1e, hi);
		@(posedge clk);
		sel <= 10'h155;
		cm <= 1;
		cl <= 24'hffffff;
		acc(1, 6'h1d, 24'h924924);
		for (int d = 0; d < 4; d++) begin
			acc(1, 6'h1e, {1'b0, d[1:0], 21'h16db6d});
			lv_all;
		end
		@(posedge clk) rst_n <= 0;
		@(posedge clk) rst_n <= 1;
		lo = 0;
		hi = 0;
		rd(6'h1e, 24'h0);
		rd(6'h1d, 24'h0);
		lv_all;
		stop_test;
	end
endmodule
